// *** hdl/lrp_auth_and_enc_counter.v ***
// Purpose: Authentication sequencer and block counter for card messaging
// Assumes: Frame decoder, cipher core and random source share clk_in
// Notes:   Cipher core handles one request at a time and answers later
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "lrp_ctrl_defs.vh"

// Operation
// - Keep a 32-bit block counter as cipher IV
// - Clear counter when either authentication starts
// - Advance counter once per 16-byte block
// - After first authentication messaging starts at one
// - After follow-on authentication messaging starts at zero
// - Keep counting while authenticated, no wrap handling
// - Present counter most significant byte first
// - Pad with 80h then zeros to 16
// - No padding inside authentication messages
// - Capability bit 1 selects this first authentication
// - Any other command aborts pending part two
// - Accept longer messages when capability length consistent
// - Part one rejected unless target key exists
// - Part one: challenge, clear counters, new identifier
// - Verify part-two MAC, then encrypt response
// - Echoed reader capabilities cut to six bytes
// - Append MAC over challenges and ciphertext
// - Follow-on needs active session or origin key
// - Follow-on keeps identifier and command counter
// - Success authenticates except origin key; failure clears
// - MAC failure: integrity code, abort, unauthenticate
// - Outside authentication truncate MAC to odd bytes 1,3,..,15
module lrp_auth_and_enc_counter (
  // Clock, reset, enable
  input  wire                clk_in,
  input  wire                arst_n_in,
  input  wire                ce_in,
  // Register port
  input  wire [`ADDR_W-1:0]  addr_in,
  input  wire [31:0]         wdata_in,
  input  wire                wr_in,
  input  wire                rd_in,
  output reg  [31:0]         rdata_out,
  // Decoded commands
  input  wire                cmd_valid_in,
  input  wire [2:0]          cmd_kind_in,
  input  wire                key_known_in,
  input  wire                key_origin_in,
  input  wire [7:0]          cap_first_in,
  input  wire                cap_len_ok_in,
  input  wire [3:0]          cap_len_in,
  input  wire [63:0]         reader_cap_in,
  // Reply to the frame builder
  output reg                 reply_valid_out,
  output reg  [7:0]          reply_code_out,
  output reg                 authed_out,
  output reg  [47:0]         cap_echo_out,
  // Cipher and MAC core
  output reg                 core_req_out,
  output reg  [1:0]          core_op_out,
  output reg                 core_key_sel_out,
  output reg  [`CTR_W-1:0]   core_iv_out,
  output reg                 core_pad_out,
  output reg                 core_trunc_out,
  output reg  [127:0]        pad_tpl_out,
  output reg  [15:0]         pad_mask_out,
  input  wire                core_done_in,
  input  wire                core_ok_in,
  input  wire [127:0]        mac_full_in,
  output reg  [63:0]         mac_trunc_out,
  // Session side effects
  output reg                 draw_chal_out,
  output reg                 draw_ident_out,
  output reg                 cmd_ctr_clr_out
);

  // One-hot states
  localparam [5:0] S_IDLE  = 6'b000001; // No pending work
  localparam [5:0] S_WAIT2 = 6'b000010; // Part one done
  localparam [5:0] S_VER   = 6'b000100; // Checking part-two MAC
  localparam [5:0] S_ENC   = 6'b001000; // Encrypting response
  localparam [5:0] S_MACG  = 6'b010000; // Building response MAC
  localparam [5:0] S_SM    = 6'b100000; // Messaging blocks

  reg  [5:0]        state_reg;   // Sequencer state
  reg  [`CTR_W-1:0] enc_ctr_reg; // Block counter
  reg               first_reg;   // Pending auth is the first kind
  reg               origin_reg;  // Pending auth targets origin key
  reg  [12:0]       blocks_reg;  // Blocks still to run
  reg               dec_reg;     // Messaging direction
  reg  [16:0]       len_reg;     // Length and no-pad flag
  reg  [7:0]        rc_reg;      // Last reply code
  wire [12:0]       pad_blocks;  // Blocks for len_reg
  wire [127:0]      pad_tpl;     // Last-block template
  wire [15:0]       pad_mask;    // Last-block pad bytes
  wire [63:0]       short_mac;   // Truncated core tag
  wire              cmd_p2;      // Command is a part two
  wire              p2_match;    // Part two of the pending kind

  // Trim or zero-extend the echoed capabilities
  function [47:0] cap_cut;
    input [63:0] cap;
    input [3:0]  len;
    integer      i;
    begin
      cap_cut = 48'h000000000000;
      for (i = 0; i < `CAP_ECHO; i = i + 1) begin
        if (i < len) begin
          cap_cut[47-8*i -: 8] = cap[63-8*i -: 8];
        end
      end
    end
  endfunction

  // Match a command kind
  function is_kind;
    input [2:0] kind;
    input [2:0] code;
    begin
      is_kind = (kind == code);
    end
  endfunction

  assign cmd_p2   = is_kind(cmd_kind_in, `CMD_FIRST_P2) ||
                    is_kind(cmd_kind_in, `CMD_NONF_P2);
  assign p2_match = is_kind(cmd_kind_in, `CMD_FIRST_P2) == first_reg;

  // Padding layout for the stored length
  pad_gen u_pad (
    .len_in     (len_reg[15:0]),
    .nopad_in   (len_reg[`LEN_NOPAD]),
    .blocks_out (pad_blocks),
    .tpl_out    (pad_tpl),
    .mask_out   (pad_mask)
  );

  // Short tag for messaging MACs
  mac_trunc u_trunc (
    .mac_in  (mac_full_in),
    .mac_out (short_mac)
  );

  // Counter as IV, byte 31:24 leaves first towards the key stream
  always @* begin
    core_iv_out = enc_ctr_reg;
  end

  // Main sequencer
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg        <= S_IDLE;
      enc_ctr_reg      <= `CTR_ZERO;
      first_reg        <= 1'b0;
      origin_reg       <= 1'b0;
      blocks_reg       <= 13'h0000;
      dec_reg          <= 1'b0;
      len_reg          <= `LEN_RESET;
      rc_reg           <= `RC_OK;
      authed_out       <= 1'b0;
      reply_valid_out  <= 1'b0;
      reply_code_out   <= `RC_OK;
      cap_echo_out     <= 48'h000000000000;
      core_req_out     <= 1'b0;
      core_op_out      <= `OP_MACV;
      core_key_sel_out <= `KEY_MAC;
      core_pad_out     <= 1'b0;
      core_trunc_out   <= 1'b0;
      pad_tpl_out      <= 128'h0;
      pad_mask_out     <= 16'h0000;
      mac_trunc_out    <= 64'h0;
      draw_chal_out    <= 1'b0;
      draw_ident_out   <= 1'b0;
      cmd_ctr_clr_out  <= 1'b0;
    end else if (ce_in) begin
      // Pulses last one cycle
      reply_valid_out <= 1'b0;
      core_req_out    <= 1'b0;
      draw_chal_out   <= 1'b0;
      draw_ident_out  <= 1'b0;
      cmd_ctr_clr_out <= 1'b0;
      // Short tags only matter outside authentication
      core_trunc_out  <= (state_reg == S_SM);
      if (core_done_in) begin
        mac_trunc_out <= short_mac;
      end
      // Length register write
      if (wr_in && addr_in == `ADDR_LEN) begin
        len_reg <= wdata_in[16:0];
      end
      if (cmd_valid_in && is_kind(cmd_kind_in, `CMD_MAC_FAIL)) begin
        // Integrity failure wins over everything in flight
        state_reg       <= S_IDLE;
        authed_out      <= 1'b0;
        rc_reg          <= `RC_INTEG;
        reply_code_out  <= `RC_INTEG;
        reply_valid_out <= 1'b1;
      end else begin
        case (state_reg)
          S_IDLE, S_WAIT2: begin
            if (cmd_valid_in) begin
              reply_valid_out <= 1'b1;
              case (cmd_kind_in)
                `CMD_FIRST_P1: begin
                  if (!cap_first_in[`CAP_LRP_BIT]) begin
                    // Standard flavour, handled elsewhere
                    state_reg      <= S_IDLE;
                    reply_code_out <= `RC_NOT_LRP;
                    rc_reg         <= `RC_NOT_LRP;
                  end else if (!key_known_in || !cap_len_ok_in) begin
                    state_reg      <= S_IDLE;
                    authed_out     <= 1'b0;
                    reply_code_out <= `RC_REJECT;
                    rc_reg         <= `RC_REJECT;
                  end else begin
                    enc_ctr_reg     <= `CTR_ZERO;
                    cmd_ctr_clr_out <= 1'b1;
                    draw_ident_out  <= 1'b1;
                    draw_chal_out   <= 1'b1;
                    first_reg       <= 1'b1;
                    origin_reg      <= key_origin_in;
                    state_reg       <= S_WAIT2;
                    reply_code_out  <= `RC_OK;
                    rc_reg          <= `RC_OK;
                  end
                end
                `CMD_NONF_P1: begin
                  if ((!authed_out && !key_origin_in) || !key_known_in) begin
                    state_reg      <= S_IDLE;
                    authed_out     <= 1'b0;
                    reply_code_out <= `RC_REJECT;
                    rc_reg         <= `RC_REJECT;
                  end else begin
                    // Identifier and command counter stay
                    enc_ctr_reg    <= `CTR_ZERO;
                    draw_chal_out  <= 1'b1;
                    first_reg      <= 1'b0;
                    origin_reg     <= key_origin_in;
                    state_reg      <= S_WAIT2;
                    reply_code_out <= `RC_OK;
                    rc_reg         <= `RC_OK;
                  end
                end
                `CMD_FIRST_P2, `CMD_NONF_P2: begin
                  if (state_reg == S_WAIT2 && p2_match && cap_len_ok_in) begin
                    // Reply comes when the whole exchange ends
                    reply_valid_out  <= 1'b0;
                    if (first_reg) begin
                      cap_echo_out <= cap_cut(reader_cap_in, cap_len_in);
                    end
                    state_reg        <= S_VER;
                    core_req_out     <= 1'b1;
                    core_op_out      <= `OP_MACV;
                    core_key_sel_out <= `KEY_MAC;
                    core_pad_out     <= 1'b0;
                  end else begin
                    state_reg      <= S_IDLE;
                    authed_out     <= 1'b0;
                    reply_code_out <= `RC_REJECT;
                    rc_reg         <= `RC_REJECT;
                  end
                end
                default: begin
                  // Unrelated command: silent, but kills a pending auth
                  reply_valid_out <= 1'b0;
                  if (state_reg == S_WAIT2) begin
                    state_reg  <= S_IDLE;
                    authed_out <= 1'b0;
                  end
                end
              endcase
            end else if (wr_in && addr_in == `ADDR_CTRL &&
                         wdata_in[`CTRL_START] && state_reg == S_IDLE) begin
              // Messaging run needs a live session
              if (!authed_out) begin
                rc_reg <= `RC_REJECT;
              end else if (pad_blocks != 13'h0000) begin
                dec_reg          <= wdata_in[`CTRL_DEC];
                blocks_reg       <= pad_blocks;
                pad_tpl_out      <= pad_tpl;
                pad_mask_out     <= pad_mask;
                state_reg        <= S_SM;
                core_req_out     <= 1'b1;
                core_op_out      <= wdata_in[`CTRL_DEC] ? `OP_DEC : `OP_ENC;
                core_key_sel_out <= `KEY_ENC;
                core_pad_out     <= (pad_blocks == 13'h0001) &&
                                    !len_reg[`LEN_NOPAD];
                rc_reg           <= `RC_OK;
              end
            end
          end
          S_VER: begin
            if (core_done_in) begin
              if (!core_ok_in) begin
                state_reg       <= S_IDLE;
                authed_out      <= 1'b0;
                reply_code_out  <= `RC_REJECT;
                rc_reg          <= `RC_REJECT;
                reply_valid_out <= 1'b1;
              end else if (first_reg) begin
                // Identifier plus both capability sets, unpadded
                state_reg        <= S_ENC;
                core_req_out     <= 1'b1;
                core_op_out      <= `OP_ENC;
                core_key_sel_out <= `KEY_ENC;
                core_pad_out     <= 1'b0;
              end else begin
                // Follow-on encrypts nothing, counter stays at zero
                state_reg        <= S_MACG;
                core_req_out     <= 1'b1;
                core_op_out      <= `OP_MACG;
                core_key_sel_out <= `KEY_MAC;
              end
            end
          end
          S_ENC: begin
            if (core_done_in) begin
              // Zero spent on the response, messaging starts at one
              enc_ctr_reg      <= enc_ctr_reg + `CTR_ONE;
              state_reg        <= S_MACG;
              core_req_out     <= 1'b1;
              core_op_out      <= `OP_MACG;
              core_key_sel_out <= `KEY_MAC;
            end
          end
          S_MACG: begin
            if (core_done_in) begin
              state_reg       <= S_IDLE;
              authed_out      <= !origin_reg;
              reply_code_out  <= `RC_OK;
              rc_reg          <= `RC_OK;
              reply_valid_out <= 1'b1;
            end
          end
          S_SM: begin
            if (core_done_in) begin
              // Plain increment: the command counter expires first
              enc_ctr_reg <= enc_ctr_reg + `CTR_ONE;
              if (!core_ok_in) begin
                // Bad padding on a decrypted command
                state_reg       <= S_IDLE;
                authed_out      <= 1'b0;
                reply_code_out  <= `RC_INTEG;
                rc_reg          <= `RC_INTEG;
                reply_valid_out <= 1'b1;
                blocks_reg      <= 13'h0000;
              end else if (blocks_reg == 13'h0001) begin
                state_reg  <= S_IDLE;
                blocks_reg <= 13'h0000;
              end else begin
                blocks_reg       <= blocks_reg - 13'h0001;
                core_req_out     <= 1'b1;
                core_op_out      <= dec_reg ? `OP_DEC : `OP_ENC;
                core_key_sel_out <= `KEY_ENC;
                core_pad_out     <= (blocks_reg == 13'h0002) &&
                                    !len_reg[`LEN_NOPAD];
              end
            end
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

  // Register read, data valid only in the cycle after the strobe
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= 32'h00000000;
    end else if (ce_in) begin
      rdata_out <= 32'h00000000;
      if (rd_in) begin
        case (addr_in)
          `ADDR_LEN: begin
            rdata_out <= {15'h0000, len_reg};
          end
          `ADDR_STATUS: begin
            rdata_out <= {16'h0000, rc_reg, 4'h0, first_reg,
                          (state_reg == S_WAIT2),
                          !(state_reg == S_IDLE || state_reg == S_WAIT2),
                          authed_out};
          end
          `ADDR_ENC: begin
            rdata_out <= enc_ctr_reg;
          end
          `ADDR_BLK: begin
            rdata_out <= {19'h00000, blocks_reg};
          end
          default: begin
            // Control and unmapped addresses read zero
            rdata_out <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule

// *** include/lrp_ctrl_defs.vh ***
// Purpose: Shared constants for the leakage-resilient messaging control
// Assumes: Included by bare name from every design file
// Notes:   Definitions only, no logic
`ifndef LRP_CTRL_DEFS_VH
`define LRP_CTRL_DEFS_VH

// Counter width and fixed values
`define CTR_W         32
`define CTR_ZERO      32'h00000000
`define CTR_ONE       32'h00000001

// Padding layout
`define BLK_BYTES     16
`define PAD_BYTE      8'h80
`define ZERO_BYTE     8'h00
`define CAP_ECHO      6
`define CAP_LRP_BIT   1

// Register byte addresses
`define ADDR_W        5
`define ADDR_CTRL     5'h00
`define ADDR_LEN      5'h04
`define ADDR_STATUS   5'h08
`define ADDR_ENC      5'h0C
`define ADDR_BLK      5'h10

// Register field positions
`define CTRL_START    0
`define CTRL_DEC      1
`define LEN_NOPAD     16
`define ST_AUTHED     0
`define ST_BUSY       1
`define ST_WAIT2      2
`define ST_FIRST      3
`define LEN_RESET     17'h00000

// Reply codes
`define RC_OK         8'h00
`define RC_REJECT     8'h01
`define RC_INTEG      8'h02
`define RC_NOT_LRP    8'h03

// Cipher core operations
`define OP_MACV       2'h0
`define OP_MACG       2'h1
`define OP_ENC        2'h2
`define OP_DEC        2'h3
`define KEY_MAC       1'b0
`define KEY_ENC       1'b1

// Command kinds from the frame decoder
`define CMD_FIRST_P1  3'h0
`define CMD_FIRST_P2  3'h1
`define CMD_NONF_P1   3'h2
`define CMD_NONF_P2   3'h3
`define CMD_OTHER     3'h4
`define CMD_MAC_FAIL  3'h5

`endif

// *** hdl/pad_gen.v ***
// Purpose: Block count and last-block padding template for a message
// Assumes: Combinational, byte 0 of a block sits in bits 127:120
// Notes:   Aligned data gets a whole extra padding block
`timescale 1ns/1ps
`include "lrp_ctrl_defs.vh"

module pad_gen (
  // Message shape
  input  wire [15:0]  len_in,
  input  wire         nopad_in,
  // Derived layout
  output wire [12:0]  blocks_out,
  output wire [127:0] tpl_out,
  output wire [15:0]  mask_out
);

  wire [3:0] rem; // Bytes in the partial block

  assign rem = len_in[3:0];
  // One extra block always when padded, partial only when not
  assign blocks_out = {1'b0, len_in[15:4]} +
                      {12'h000, (nopad_in ? |rem : 1'b1)};

  genvar k;
  generate
    for (k = 0; k < `BLK_BYTES; k = k + 1) begin : g_byte
      // 80h at the first free byte, zeros after it
      assign tpl_out[127-8*k -: 8] = (!nopad_in && k == rem) ?
                                     `PAD_BYTE : `ZERO_BYTE;
      assign mask_out[k] = !nopad_in && (k >= rem);
    end
  endgenerate

endmodule

// *** hdl/mac_trunc.v ***
// Purpose: Cut a 16-byte MAC to 8 bytes for ordinary messaging
// Assumes: Byte 0 of the input is bits 127:120
// Notes:   Keeps bytes 1,3,..,15 in their original order
`timescale 1ns/1ps
`include "lrp_ctrl_defs.vh"

module mac_trunc (
  // Full tag
  input  wire [127:0] mac_in,
  // Short tag
  output wire [63:0]  mac_out
);

  genvar j;
  generate
    for (j = 0; j < 8; j = j + 1) begin : g_keep
      // Every second byte, most significant first
      assign mac_out[63-8*j -: 8] = mac_in[119-16*j -: 8];
    end
  endgenerate

endmodule

// *** verif/core_model.sv ***
// Purpose: Cipher core stand-in that answers one request at a time
// Assumes: Requests are single-cycle pulses
// Notes:   Latency alternates 2 and 4 cycles; ok and tag churn when idle
`timescale 1ns/1ps
module core_model (
  // Clock and reset
  input  wire         clk_in,
  input  wire         arst_n_in,
  // Request side
  input  wire         req_in,
  input  wire         bad_in,
  // Answer side
  output reg          done_out,
  output reg          ok_out,
  output reg  [127:0] mac_out
);
  reg [1:0] wait_reg; // Cycles left before done
  reg       slow_reg; // Picks the slow answer next
  // Done never in the request cycle
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wait_reg <= 2'h0;
      slow_reg <= 1'b0;
      done_out <= 1'b0;
      ok_out   <= 1'b0;
      mac_out  <= 128'h0;
    end else begin
      done_out <= (wait_reg == 2'h1);
      ok_out   <= (wait_reg == 2'h1) ? !bad_in : ~ok_out;
      mac_out  <= {mac_out[119:0], mac_out[127:120] + 8'h3B};
      if (req_in) begin
        wait_reg <= slow_reg ? 2'h3 : 2'h1;
        slow_reg <= ~slow_reg;
      end else if (wait_reg != 2'h0) begin
        wait_reg <= wait_reg - 2'h1;
      end
    end
  end
endmodule

// *** verif/lrp_auth_and_enc_counter_checker.sv ***
// Purpose: Port assertions for the sequencer
// Assumes: ce_in drops only while idle
// Notes:   Bound to the top module by name
`timescale 1ns/1ps
`include "lrp_ctrl_defs.vh"
module lrp_auth_and_enc_counter_checker (
  input wire              clk_in,
  input wire              arst_n_in,
  input wire              cmd_valid_in,
  input wire [2:0]        cmd_kind_in,
  input wire              key_origin_in,
  input wire              authed_out,
  input wire              reply_valid_out,
  input wire [7:0]        reply_code_out,
  input wire              core_req_out,
  input wire [1:0]        core_op_out,
  input wire [`CTR_W-1:0] core_iv_out,
  input wire              core_done_in,
  input wire [127:0]      mac_full_in,
  input wire [63:0]       mac_trunc_out,
  input wire              draw_chal_out,
  input wire              draw_ident_out,
  input wire              cmd_ctr_clr_out
);
  reg         pend_reg; // Core request not yet answered
  wire [63:0] odd_bytes = {mac_full_in[119:112], mac_full_in[103:96], mac_full_in[87:80],
    mac_full_in[71:64], mac_full_in[55:48], mac_full_in[39:32], mac_full_in[23:16],
    mac_full_in[7:0]};
  // Tracks the outstanding core request
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= core_req_out | (pend_reg & ~core_done_in);
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  property p_one_req; core_req_out |-> !pend_reg; endproperty
  property p_integ; cmd_valid_in && cmd_kind_in == `CMD_MAC_FAIL |=> reply_valid_out &&
    reply_code_out == `RC_INTEG && !authed_out; endproperty
  property p_clr; draw_chal_out |-> core_iv_out == `CTR_ZERO; endproperty
  property p_ident; draw_ident_out |-> draw_chal_out && cmd_ctr_clr_out; endproperty
  property p_step; core_done_in && core_op_out[1] |=> core_iv_out == $past(core_iv_out) + 1;
  endproperty
  property p_hold; $changed(core_iv_out) |-> $past(core_done_in) || core_iv_out == 0;
  endproperty
  property p_trunc; core_done_in |=> mac_trunc_out == $past(odd_bytes); endproperty
  property p_nonf; cmd_valid_in && cmd_kind_in == `CMD_NONF_P1 && !authed_out &&
    !key_origin_in |=> !(reply_valid_out && reply_code_out == `RC_OK); endproperty
  property p_fail; reply_valid_out && (reply_code_out == `RC_REJECT ||
    reply_code_out == `RC_INTEG) |-> !authed_out; endproperty
  a_one_req: assert property (p_one_req) else $error("two core requests");
  a_integ: assert property (p_integ) else $error("no integrity reply");
  a_clr: assert property (p_clr) else $error("counter not cleared");
  a_ident: assert property (p_ident) else $error("identifier drawn alone");
  a_step: assert property (p_step) else $error("counter did not step");
  a_hold: assert property (p_hold) else $error("counter moved");
  a_trunc: assert property (p_trunc) else $error("short tag wrong");
  a_nonf: assert property (p_nonf) else $error("follow-on accepted");
  a_fail: assert property (p_fail) else $error("failure kept auth");
  c_first: cover property (draw_ident_out);
  c_enc: cover property (core_done_in && core_op_out == `OP_ENC);
  c_integ: cover property (reply_valid_out && reply_code_out == `RC_INTEG);
endmodule
bind lrp_auth_and_enc_counter lrp_auth_and_enc_counter_checker chk_i (.*);

// *** verif/test_lrp_auth_and_enc_counter.sv ***
// Purpose: Bench for the sequencer and counter
// Assumes: Core stand-in answers every request
// Notes:   Each task judges its own replies
`timescale 1ns/1ps
`include "lrp_ctrl_defs.vh"
module test_lrp_auth_and_enc_counter;
  reg               clk_in = 1'b0;
  reg               arst_n_in = 1'b0;
  reg               ce_in = 1'b1;
  reg [`ADDR_W-1:0] addr_in = 5'h00;
  reg [31:0]        wdata_in = 32'h0;
  reg               wr_in = 1'b0, rd_in = 1'b0, cmd_valid_in = 1'b0, bad_mac = 1'b0;
  reg               key_known_in = 1'b1, key_origin_in = 1'b0, cap_len_ok_in = 1'b1;
  reg [2:0]         cmd_kind_in = 3'h0;
  reg [7:0]         cap_first_in = 8'hAB; // Bit 1 set among other bits
  reg [3:0]         cap_len_in = 4'h8;
  reg [63:0]        reader_cap_in = 64'h1122334455667788;
  wire [31:0]       rdata_out;
  wire [7:0]        reply_code_out;
  wire [47:0]       cap_echo_out;
  wire [127:0]      mac_full_in;
  wire [15:0]       pad_mask_out;
  wire              reply_valid_out, authed_out, core_req_out, core_done_in, core_ok_in;
  wire              draw_ident_out;
  int               num_errors = 0, n_tests = 0, cyc = 0, idents = 0;
  reg [31:0]        d;
  core_model core_i (.clk_in, .arst_n_in, .req_in(core_req_out), .bad_in(bad_mac),
    .done_out(core_done_in), .ok_out(core_ok_in), .mac_out(mac_full_in));
  lrp_auth_and_enc_counter dut (.*, .core_op_out(), .core_key_sel_out(), .core_iv_out(),
    .core_pad_out(), .core_trunc_out(), .pad_tpl_out(), .mac_trunc_out(), .draw_chal_out(),
    .cmd_ctr_clr_out());
  always #25 clk_in = ~clk_in;
  // Hang guard, identifier tally
  always @(posedge clk_in) begin
    cyc++;
    if (draw_ident_out === 1'b1) idents++;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test;
    end
  end
  task end_of_test;
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string n, input [63:0] g, input [63:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input [4:0] a, input [31:0] v);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // Data stand one cycle after the strobe
  task rd(input [4:0] a, output [31:0] v);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  task rchk(input string n, input [4:0] a, input [31:0] e);
    rd(a, d);
    chk(n, d, e);
  endtask
  task pulse(input [2:0] k);
    @(posedge clk_in);
    cmd_valid_in <= 1'b1;
    cmd_kind_in <= k;
    @(posedge clk_in);
    cmd_valid_in <= 1'b0;
  endtask
  // Good part two answers after the core chain
  task cmd(input [2:0] k, input [7:0] e);
    integer i;
    pulse(k);
    #1;
    for (i = 0; i < 40 && reply_valid_out !== 1'b1; i++) @(posedge clk_in) #1;
    chk("reply", {reply_valid_out, reply_code_out}, {1'b1, e});
  endtask
  task run(input [31:0] lenw, input [31:0] e);
    integer i;
    wr(`ADDR_LEN, lenw);
    wr(`ADDR_CTRL, 32'h1);
    d = 32'h2;
    for (i = 0; i < 60 && d[`ST_BUSY] !== 1'b0; i++) rd(`ADDR_STATUS, d);
    rchk("enc_counter", `ADDR_ENC, e);
  endtask
  task t_regs;
    rchk("enc_counter", `ADDR_ENC, `CTR_ZERO);
    ce_in <= 1'b0;
    wr(`ADDR_LEN, 32'h5);
    ce_in <= 1'b1;
    rchk("len", `ADDR_LEN, 32'h0);
    rchk("unmapped", 5'h14, 32'h0);
  endtask
  task t_refuse;
    integer i;
    for (i = 0; i < 4; i++) begin
      key_known_in <= (i != 0);
      cap_first_in <= (i == 1) ? 8'hFD : 8'hAB;
      cap_len_ok_in <= (i != 2);
      cmd((i == 3) ? `CMD_NONF_P1 : `CMD_FIRST_P1, (i == 1) ? `RC_NOT_LRP : `RC_REJECT);
    end
    chk("authed", authed_out, 0);
  endtask
  task t_first(input [3:0] n, input [47:0] echo);
    integer c;
    c = idents;
    cap_len_in <= n;
    cmd(`CMD_FIRST_P1, `RC_OK);
    rchk("enc_counter", `ADDR_ENC, `CTR_ZERO);
    chk("idents", idents, c + 1);
    cmd(`CMD_FIRST_P2, `RC_OK);
    chk("authed", authed_out, 1);
    chk("cap_echo", cap_echo_out, echo);
    rchk("enc_counter", `ADDR_ENC, `CTR_ONE);
  endtask
  // From one: 64 bytes 5 steps, 20 two, 32 unpadded two
  task t_msg;
    run(32'd64, 32'd6);
    run(32'd20, 32'd8);
    chk("pad_mask", pad_mask_out, 16'hFFF0);
    run(32'h10020, 32'd10);
  endtask
  task t_nonf(input org, input au);
    integer c;
    c = idents;
    key_origin_in <= org;
    cmd(`CMD_NONF_P1, `RC_OK);
    cmd(`CMD_NONF_P2, `RC_OK);
    chk("authed", authed_out, au);
    rchk("enc_counter", `ADDR_ENC, `CTR_ZERO);
    chk("idents", idents, c);
    key_origin_in <= 1'b0;
  endtask
  task t_abort;
    cmd(`CMD_FIRST_P1, `RC_OK);
    pulse(`CMD_OTHER);
    repeat (2) @(posedge clk_in);
    chk("authed", authed_out, 0);
  endtask
  task t_badmac;
    bad_mac <= 1'b1;
    cmd(`CMD_FIRST_P1, `RC_OK);
    cmd(`CMD_FIRST_P2, `RC_REJECT);
    chk("authed", authed_out, 0);
    bad_mac <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_regs;
    t_refuse;
    t_first(4'h8, 48'h112233445566);
    t_msg;
    cmd(`CMD_MAC_FAIL, `RC_INTEG);
    chk("authed", authed_out, 0);
    t_nonf(1'b1, 1'b0);
    t_first(4'h4, 48'h112233440000);
    t_nonf(1'b0, 1'b1);
    t_abort;
    t_badmac;
    end_of_test;
  end
endmodule
